// ===== rtl/boundary_scan_tap.sv
/*
 Boundary-scan test access port with its controller, instruction and
 data registers, a buffered path for update words into the core clock
 domain, and the probe pin steering.
 Assumes tck comes from an external tester and is unrelated to sys_clk;
 device pins are split into input, output and enable by the pad ring.
*/
`timescale 1ns/1ps
`include "tap_map.svh"

// ----------------------------------------------------------------------
// Update word buffer
// ----------------------------------------------------------------------
module sync_fifo #(
    parameter int WIDTH = `BSR_LEN,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    // Fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } fifoSt_t;

    fifoSt_t s_r;
    fifoSt_t s_nxt;
    logic    push;
    logic    pop;

    assign inReady  = (s_r.cnt != (AW+1)'(DEPTH));
    assign outValid = (s_r.cnt != '0);
    assign outData  = s_r.mem[s_r.rp];
    assign push     = ce & inValid & inReady;
    assign pop      = ce & outValid & outReady;

    always_comb begin
        s_nxt = s_r;
        if (push) begin
            s_nxt.mem[s_r.wp] = inData;
            s_nxt.wp = s_r.wp + 1'b1;
        end
        if (pop) begin
            s_nxt.rp = s_r.rp + 1'b1;
        end
        s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end
endmodule

// ----------------------------------------------------------------------
// Test access port
// ----------------------------------------------------------------------
module boundary_scan_tap #(
    parameter logic [7:0]  ID_MARKER  = 8'h01,  // Arbitrary value
    parameter logic [7:0]  ID_NUMBER  = 8'h5A,  // Arbitrary value
    parameter logic [11:0] ID_PART    = 12'h123, // Arbitrary value
    parameter logic [3:0]  ID_VERSION = 4'h1    // Arbitrary value
) (
    // Core clock domain
    input  wire logic                sys_clk,
    input  wire logic                rst,
    input  wire logic                ce,
    // Test access pins
    input  wire logic                tck,
    input  wire logic                tms,
    input  wire logic                tdi,
    output logic                     tdo,
    output logic                     tdoOe,
    // Device pins and core side
    input  wire logic [`BSR_LEN-1:0] ioI,
    output logic [`BSR_LEN-1:0]      ioO,
    output logic [`BSR_LEN-1:0]      ioOe,
    input  wire logic [`BSR_LEN-1:0] coreO,
    input  wire logic [`BSR_LEN-1:0] coreOe,
    output logic [`BSR_LEN-1:0]      coreI,
    input  wire logic                drvReady,
    output logic                     extestOn,
    // Probe pins and probe circuit
    input  wire logic                probeMode,
    input  wire logic [`PRB_LEN-1:0] probePinI,
    output logic [`PRB_LEN-1:0]      probePinO,
    output logic [`PRB_LEN-1:0]      probePinOe,
    input  wire logic [`PRB_LEN-1:0] probeDrv,
    output logic [`PRB_LEN-1:0]      probeSense,
    input  wire logic [`PRB_LEN-1:0] userProbeO,
    input  wire logic [`PRB_LEN-1:0] userProbeOe,
    output logic [`PRB_LEN-1:0]      probeCoreI
);
    localparam logic [`ID_LEN-1:0] ID_WORD = {ID_VERSION, ID_PART, ID_NUMBER, ID_MARKER};

    tap_pkg::tckSt_t     t_r;
    tap_pkg::tckSt_t     t_nxt;
    tap_pkg::sysSt_t     s_r;
    tap_pkg::sysSt_t     s_nxt;
    logic                tdo_r;
    logic                tdoOe_r;
    logic                tdoNxt;
    logic                bsrSel;
    logic                fifoInReady;
    logic                fifoOutValid;
    logic [`BSR_LEN-1:0] fifoOutData;
    logic                fifoPush;
    logic                fifoPop;

    // ------------------------------------------------------------------
    // Controller
    // ------------------------------------------------------------------
    function automatic tap_pkg::tapState_t nextState(tap_pkg::tapState_t s, logic m);
        case (s)
            tap_pkg::TLR:   nextState = m ? tap_pkg::TLR   : tap_pkg::RTI;
            tap_pkg::RTI:   nextState = m ? tap_pkg::SELDR : tap_pkg::RTI;
            tap_pkg::SELDR: nextState = m ? tap_pkg::SELIR : tap_pkg::CAPDR;
            tap_pkg::CAPDR: nextState = m ? tap_pkg::EX1DR : tap_pkg::SHDR;
            tap_pkg::SHDR:  nextState = m ? tap_pkg::EX1DR : tap_pkg::SHDR;
            tap_pkg::EX1DR: nextState = m ? tap_pkg::UPDR  : tap_pkg::PDR;
            tap_pkg::PDR:   nextState = m ? tap_pkg::EX2DR : tap_pkg::PDR;
            tap_pkg::EX2DR: nextState = m ? tap_pkg::UPDR  : tap_pkg::SHDR;
            tap_pkg::UPDR:  nextState = m ? tap_pkg::SELDR : tap_pkg::RTI;
            tap_pkg::SELIR: nextState = m ? tap_pkg::TLR   : tap_pkg::CAPIR;
            tap_pkg::CAPIR: nextState = m ? tap_pkg::EX1IR : tap_pkg::SHIR;
            tap_pkg::SHIR:  nextState = m ? tap_pkg::EX1IR : tap_pkg::SHIR;
            tap_pkg::EX1IR: nextState = m ? tap_pkg::UPIR  : tap_pkg::PIR;
            tap_pkg::PIR:   nextState = m ? tap_pkg::EX2IR : tap_pkg::PIR;
            tap_pkg::EX2IR: nextState = m ? tap_pkg::UPIR  : tap_pkg::SHIR;
            tap_pkg::UPIR:  nextState = m ? tap_pkg::SELDR : tap_pkg::RTI;
            default:        nextState = tap_pkg::TLR;
        endcase
    endfunction

    // Boundary register in use for EXTEST and SAMPLE/PRELOAD
    assign bsrSel = (t_r.ir == `IR_EXTEST) || (t_r.ir == `IR_SAMPLE);

    always_comb begin
        t_nxt      = t_r;
        t_nxt.pin1 = ioI;
        t_nxt.pin2 = t_r.pin1;
        t_nxt.ack1 = s_r.ack;
        t_nxt.ack2 = t_r.ack1;
        t_nxt.st   = nextState(t_r.st, tms);
        case (t_r.st)
            tap_pkg::TLR: begin
                t_nxt.ir     = `IR_IDCODE;
                t_nxt.extest = 1'b0;
            end
            tap_pkg::CAPIR: begin
                t_nxt.irSh = `IR_CAPTURE;
            end
            tap_pkg::SHIR: begin
                t_nxt.irSh = {tdi, t_r.irSh[`IR_LEN-1:1]};
            end
            tap_pkg::UPIR: begin
                t_nxt.ir     = t_r.irSh;
                t_nxt.extest = (t_r.irSh == `IR_EXTEST);
            end
            tap_pkg::CAPDR: begin
                if (bsrSel) begin
                    t_nxt.bsSh = t_r.pin2;
                end else if (t_r.ir == `IR_IDCODE) begin
                    t_nxt.idSh = ID_WORD;
                end else begin
                    t_nxt.byp = 1'b0;
                end
            end
            tap_pkg::SHDR: begin
                if (bsrSel) begin
                    t_nxt.bsSh = {tdi, t_r.bsSh[`BSR_LEN-1:1]};
                end else if (t_r.ir == `IR_IDCODE) begin
                    t_nxt.idSh = {tdi, t_r.idSh[`ID_LEN-1:1]};
                end else begin
                    t_nxt.byp = tdi;
                end
            end
            tap_pkg::UPDR: begin
                // Dropped while the previous word is still unacknowledged
                if (bsrSel && (t_r.req == t_r.ack2)) begin
                    t_nxt.upd = t_r.bsSh;
                    t_nxt.req = ~t_r.req;
                end
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            t_r       <= '0;
            t_r.st    <= tap_pkg::TLR;
            t_r.ir    <= `IR_IDCODE;
        end else begin
            t_r <= t_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Serial output on the falling edge
    // ------------------------------------------------------------------
    always_comb begin
        if (t_r.st == tap_pkg::SHIR) begin
            tdoNxt = t_r.irSh[0];
        end else if (bsrSel) begin
            tdoNxt = t_r.bsSh[0];
        end else if (t_r.ir == `IR_IDCODE) begin
            tdoNxt = t_r.idSh[0];
        end else begin
            tdoNxt = t_r.byp;
        end
    end

    always_ff @(negedge tck or posedge rst) begin
        if (rst) begin
            tdo_r   <= 1'b0;
            tdoOe_r <= 1'b0;
        end else begin
            tdo_r   <= tdoNxt;
            tdoOe_r <= (t_r.st == tap_pkg::SHIR) || (t_r.st == tap_pkg::SHDR);
        end
    end

    assign tdo   = tdo_r;
    assign tdoOe = tdoOe_r;

    // ------------------------------------------------------------------
    // Core clock domain
    // ------------------------------------------------------------------
    assign fifoPush = ce && (s_r.req2 != s_r.ack) && fifoInReady;
    assign fifoPop  = ce && fifoOutValid && drvReady;

    sync_fifo #(
        .WIDTH (`BSR_LEN),
        .DEPTH (`FIFO_DEPTH)
    ) updFifo (
        .clk      (sys_clk),
        .rst      (rst),
        .ce       (ce),
        .inValid  (s_r.req2 != s_r.ack),
        .inReady  (fifoInReady),
        .inData   (t_r.upd),
        .outValid (fifoOutValid),
        .outReady (drvReady),
        .outData  (fifoOutData)
    );

    always_comb begin
        s_nxt      = s_r;
        s_nxt.req1 = t_r.req;
        s_nxt.req2 = s_r.req1;
        s_nxt.ext1 = t_r.extest;
        s_nxt.ext2 = s_r.ext1;
        s_nxt.prb1 = probeMode;
        s_nxt.prb2 = s_r.prb1;
        s_nxt.io1  = ioI;
        s_nxt.io2  = s_r.io1;
        s_nxt.pp1  = probePinI;
        s_nxt.pp2  = s_r.pp1;
        if (fifoPush) begin
            s_nxt.ack = ~s_r.ack;
        end
        if (fifoPop) begin
            s_nxt.drive = fifoOutData;
        end
        // Boundary cells take the pins in EXTEST
        s_nxt.ioO   = s_r.ext2 ? s_r.drive : coreO;
        s_nxt.ioOe  = s_r.ext2 ? {`BSR_LEN{1'b1}} : coreOe;
        s_nxt.coreI = s_r.io2;
        if (s_r.prb2) begin
            s_nxt.pO     = probeDrv;
            s_nxt.pOe    = `PRB_OE_MASK;
            s_nxt.pCoreI = '0;
            s_nxt.pSense = s_r.pp2 & ~`PRB_OE_MASK;
        end else begin
            s_nxt.pO     = userProbeO;
            s_nxt.pOe    = userProbeOe;
            s_nxt.pCoreI = s_r.pp2;
            s_nxt.pSense = '0;
        end
        if (!ce) begin
            s_nxt = s_r;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ioO        = s_r.ioO;
    assign ioOe       = s_r.ioOe;
    assign coreI      = s_r.coreI;
    assign extestOn   = s_r.ext2;
    assign probePinO  = s_r.pO;
    assign probePinOe = s_r.pOe;
    assign probeCoreI = s_r.pCoreI;
    assign probeSense = s_r.pSense;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    AST_TMS_RESET: assert property (@(posedge tck) disable iff (rst)
        tms [*5] |=> (t_r.st == tap_pkg::TLR)) else $error("five high mode clocks did not reset");

    AST_IDLE_STEP: assert property (@(posedge tck) disable iff (rst)
        (t_r.st == tap_pkg::TLR) && !tms |=> (t_r.st == tap_pkg::RTI)) else $error("low mode left reset wrong");

    AST_RESET_INSTR: assert property (@(posedge tck) disable iff (rst)
        (t_r.st == tap_pkg::TLR) |=> (t_r.ir == `IR_IDCODE) && !t_r.extest) else $error("reset instruction wrong");

    AST_ID_CAPTURE: assert property (@(posedge tck) disable iff (rst)
        (t_r.st == tap_pkg::CAPDR) && (t_r.ir == `IR_IDCODE) |=> (t_r.idSh == ID_WORD))
        else $error("identification word not captured");

    AST_BYPASS_BIT: assert property (@(posedge tck) disable iff (rst)
        (t_r.st == tap_pkg::SHDR) && (t_r.ir == `IR_BYPASS) |=> (t_r.byp == $past(tdi)))
        else $error("bypass bit did not follow input");

    AST_IR_SHIFT: assert property (@(posedge tck) disable iff (rst)
        (t_r.st == tap_pkg::CAPIR) ##1 (t_r.st == tap_pkg::SHIR)
        |-> (t_r.irSh == `IR_CAPTURE) ##1 (t_r.irSh[`IR_LEN-1] == $past(tdi)))
        else $error("instruction capture or shift wrong");

    AST_TDO_LSB: assert property (@(posedge tck) disable iff (rst)
        (t_r.st == tap_pkg::SHDR) && ($past(t_r.st) == tap_pkg::SHDR) && (t_r.ir == `IR_IDCODE)
        |-> tdo == t_r.idSh[0] && tdoOe) else $error("serial output not the register end");

    AST_BSR_CAPTURE: assert property (@(posedge tck) disable iff (rst)
        (t_r.st == tap_pkg::CAPDR) && bsrSel |=> (t_r.bsSh == $past(t_r.pin2)))
        else $error("boundary cells did not capture pins");

    AST_EXTEST_DRIVE: assert property (@(posedge sys_clk) disable iff (rst)
        ce && s_r.ext2 |=> (ioOe == {`BSR_LEN{1'b1}}) && (ioO == $past(s_r.drive)))
        else $error("pins not driven by boundary cells");

    AST_PROBE_BLOCK: assert property (@(posedge sys_clk) disable iff (rst)
        ce && s_r.prb2 |=> (probeCoreI == '0) && (probePinOe == `PRB_OE_MASK))
        else $error("user signals reached core in probe mode");

    COV_TMS_RESET: cover property (@(posedge tck) disable iff (rst)
        (t_r.st == tap_pkg::SHDR) && tms ##1 tms [*4] ##1 (t_r.st == tap_pkg::TLR));
    COV_ID_SHIFT: cover property (@(posedge tck) disable iff (rst)
        (t_r.ir == `IR_IDCODE) && (t_r.st == tap_pkg::SHDR) [*8]);
    COV_UPD_PUSH: cover property (@(posedge sys_clk) disable iff (rst)
        fifoPush ##[1:50] fifoPop);
endmodule

// ===== rtl/tap_map.svh
/*
 Constants of the boundary-scan test port: lengths, instruction codes,
 field positions, reset hold count and buffer depth.
 Assumes it is included by its bare name from the package and the block.
*/
// Overview of operation
// - Four test pins: clock, data in/out, mode.
// - Controller state held in four bits.
// - Mode-select sampled on rising test clock decides.
// - Controller derives all test controls from two.
// - Power-up starts in Test-Logic-Reset.
// - Five high mode-select clocks force reset.
// - Decode EXTEST, SAMPLE/PRELOAD, BYPASS, plus extras.
// - Three data registers between serial in/out.
// - Bypass selected when nothing else accessed.
// - 32-bit identification register, four fields.
// - Boundary cells capture and drive every pin; here the probe pins have no cells.
// - Probe mode: probe drives pins, user blocked.
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH

// Register lengths
`define IR_LEN        4
`define ID_LEN        32
`define BSR_LEN       8
`define PRB_LEN       5

// Instruction codes
`define IR_EXTEST     4'h0
`define IR_SAMPLE     4'h1
`define IR_IDCODE     4'h2
`define IR_BYPASS     4'hF
`define IR_CAPTURE    4'h5

// Identification fields
`define ID_MARK_LSB   0
`define ID_NUM_LSB    8
`define ID_PART_LSB   16
`define ID_VER_LSB    28

// Probe pin positions and drive mask
`define PRB_OUT_A     0
`define PRB_OUT_B     1
`define PRB_SER_IN    2
`define PRB_SER_OUT   3
`define PRB_CLOCK     4
`define PRB_OE_MASK   5'h0B

// Reset hold and buffer
`define TMS_RST_CLKS  5
`define FIFO_DEPTH    8

`endif

// ===== rtl/tap_pkg.sv
/*
 Types of the boundary-scan test port: controller states and the
 state records of both clock domains.
 Assumes tap_map.svh is on the include path.
*/
`include "tap_map.svh"

package tap_pkg;

    typedef enum logic [3:0] {
        TLR   = 4'hF, RTI   = 4'hC, SELDR = 4'h7, CAPDR = 4'h6,
        SHDR  = 4'h2, EX1DR = 4'h1, PDR   = 4'h3, EX2DR = 4'h0,
        UPDR  = 4'h5, SELIR = 4'h4, CAPIR = 4'hE, SHIR  = 4'hA,
        EX1IR = 4'h9, PIR   = 4'hB, EX2IR = 4'h8, UPIR  = 4'hD
    } tapState_t;

    typedef struct packed {
        tapState_t             st;
        logic [`IR_LEN-1:0]    irSh;
        logic [`IR_LEN-1:0]    ir;
        logic                  extest;
        logic                  byp;
        logic [`ID_LEN-1:0]    idSh;
        logic [`BSR_LEN-1:0]   bsSh;
        logic [`BSR_LEN-1:0]   upd;
        logic [`BSR_LEN-1:0]   pin1;
        logic [`BSR_LEN-1:0]   pin2;
        logic                  req;
        logic                  ack1;
        logic                  ack2;
    } tckSt_t;

    typedef struct packed {
        logic                  req1;
        logic                  req2;
        logic                  ack;
        logic                  ext1;
        logic                  ext2;
        logic                  prb1;
        logic                  prb2;
        logic [`BSR_LEN-1:0]   io1;
        logic [`BSR_LEN-1:0]   io2;
        logic [`PRB_LEN-1:0]   pp1;
        logic [`PRB_LEN-1:0]   pp2;
        logic [`BSR_LEN-1:0]   drive;
        logic [`BSR_LEN-1:0]   ioO;
        logic [`BSR_LEN-1:0]   ioOe;
        logic [`BSR_LEN-1:0]   coreI;
        logic [`PRB_LEN-1:0]   pO;
        logic [`PRB_LEN-1:0]   pOe;
        logic [`PRB_LEN-1:0]   pCoreI;
        logic [`PRB_LEN-1:0]   pSense;
    } sysSt_t;

endpackage

// ===== sim/jtag_tester.sv
/*
 Behavioural model of the external boundary-scan tester: it makes the
 test clock, drives mode-select and data-in, and reads data-out.
 Assumes the port under test starts in Test-Logic-Reset and that the
 caller enters shift or scan tasks from Run-Test/Idle.
*/
`timescale 1ns/1ps

module jtag_tester #(
    parameter int HALF = 16
) (
    // Test access pins
    output logic     tck,
    output logic     tms,
    output logic     tdi,
    input  wire logic tdo,
    input  wire logic tdoOe
);
    logic lastTdo;
    logic tdoSeen;
    logic oeNow;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        lastTdo = 1'b0;
        oeNow = 1'b0;
    end

    // ------------------------------------------------------------
    // Released data-out shows no stale value
    // ------------------------------------------------------------
    always @(tdo or tdoOe) begin
        if (tdoOe) begin
            lastTdo = tdo;
        end
    end
    assign tdoSeen = tdoOe ? tdo : ~lastTdo;

    // ------------------------------------------------------------
    // One test clock; clock stands low between calls
    // ------------------------------------------------------------
    task automatic step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #(HALF);
        q = tdoSeen;
        oeNow = tdoOe;
        tck = 1'b1;
        #(HALF);
        tck = 1'b0;
    endtask

    task automatic forceReset();
        logic q;
        repeat (5) step(1'b1, 1'b0, q);
    endtask

    task automatic idle(input int n);
        logic q;
        repeat (n) step(1'b0, 1'b0, q);
    endtask

    // Full scan from idle back to idle, LSB first
    task automatic scan(input logic ir, input int n, input logic [31:0] din,
                        output logic [31:0] dout, output logic oe);
        logic q;
        dout = '0;
        oe = 1'b1;
        step(1'b1, 1'b0, q);
        if (ir) begin
            step(1'b1, 1'b0, q);
        end
        step(1'b0, 1'b0, q);
        step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q);
            dout[i] = q;
            oe = oe & oeNow;
        end
        step(1'b1, 1'b0, q);
        step(1'b0, 1'b0, q);
    endtask
endmodule

// ===== sim/tb_boundary_scan_tap.sv
/*
 Self-checking bench of the boundary-scan test port: identification,
 bypass, sample, external test with buffered updates, probe steering
 and forced controller reset.
 Assumes jtag_tester drives the test pins and tap_map.svh is included.
*/
`timescale 1ns/1ps
`include "tap_map.svh"

module tb_boundary_scan_tap;
    localparam logic [7:0]  MARK   = 8'h01;  // Arbitrary value
    localparam logic [7:0]  NUM    = 8'h5A;  // Arbitrary value
    localparam logic [11:0] PART   = 12'h123;  // Arbitrary value
    localparam logic [3:0]  VER    = 4'h1;  // Arbitrary value
    localparam logic [31:0] ID_EXP = {VER, PART, NUM, MARK};

    logic                sys_clk, rst, ce, drvReady, probeMode;
    logic                tck, tms, tdi, tdo, tdoOe, extestOn, oe;
    logic [`BSR_LEN-1:0] ioI, ioO, ioOe, coreO, coreOe, coreI;
    logic [`PRB_LEN-1:0] probePinI, probePinO, probePinOe, probeDrv;
    logic [`PRB_LEN-1:0] probeSense, userProbeO, userProbeOe, probeCoreI;
    logic [31:0]         dout;
    int                  num_errors = 0;
    int                  samples_checked = 0;

    jtag_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe));

    boundary_scan_tap #(.ID_MARKER(MARK), .ID_NUMBER(NUM), .ID_PART(PART), .ID_VERSION(VER)) uut (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoOe(tdoOe), .ioI(ioI), .ioO(ioO), .ioOe(ioOe), .coreO(coreO), .coreOe(coreOe),
        .coreI(coreI), .drvReady(drvReady), .extestOn(extestOn), .probeMode(probeMode),
        .probePinI(probePinI), .probePinO(probePinO), .probePinOe(probePinOe),
        .probeDrv(probeDrv), .probeSense(probeSense), .userProbeO(userProbeO),
        .userProbeOe(userProbeOe), .probeCoreI(probeCoreI));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic complete_run();
        $display("mismatches %0d, comparisons %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        tester.idle(1);
        tester.scan(1'b0, 32, 32'h0, dout, oe);
        chk("idcode", ID_EXP, dout);
        chk("tdoOe in shift", 32'h1, {31'h0, oe});
        $display("test reset finished");
    endtask

    task automatic t_bypass();
        logic [3:0] codes [3];
        codes = '{`IR_BYPASS, 4'h7, 4'h3};
        foreach (codes[i]) begin
            tester.scan(1'b1, 4, {28'h0, codes[i]}, dout, oe);
            chk("ir capture", 32'h5, dout);
            tester.scan(1'b0, 8, 32'hB6, dout, oe);
            chk("bypass path", (32'hB6 << 1) & 32'hFF, dout);
        end
        $display("test bypass finished");
    endtask

    task automatic t_sample();
        cyc(1);
        ioI = 8'hA5;
        coreO = 8'h5A;
        coreOe = 8'hF0;
        drvReady = 1'b1;
        tester.scan(1'b1, 4, {28'h0, `IR_SAMPLE}, dout, oe);
        tester.scan(1'b0, 8, 32'h3C, dout, oe);
        chk("sampled pins", 32'hA5, dout);
        cyc(4);
        chk("core drive", 32'h5A, ioO);
        chk("core enable", 32'hF0, ioOe);
        chk("pins to core", 32'hA5, coreI);
        chk("extest off", 32'h0, extestOn);
        $display("test sample finished");
    endtask

    task automatic t_extest();
        tester.scan(1'b1, 4, {28'h0, `IR_EXTEST}, dout, oe);
        cyc(8);
        chk("extest on", 32'h1, extestOn);
        chk("extest enable", 32'hFF, ioOe);
        chk("preload drive", 32'h3C, ioO);
        drvReady = 1'b0;
        for (int k = 1; k <= `FIFO_DEPTH; k++) begin
            tester.scan(1'b0, 8, 32'(k * 17), dout, oe);
            chk("extest capture", 32'hA5, dout);
            tester.idle(24);
        end
        cyc(1);
        chk("stalled drive", 32'h3C, ioO);
        ce = 1'b0;
        drvReady = 1'b1;
        cyc(3);
        chk("frozen drive", 32'h3C, ioO);
        drvReady = 1'b0;
        ce = 1'b1;
        cyc(1);
        for (int k = 1; k <= `FIFO_DEPTH; k++) begin
            drvReady = 1'b1;
            cyc(1);
            drvReady = 1'b0;
            cyc(2);
            chk("drained word", 32'(k * 17), ioO);
        end
        drvReady = 1'b1;
        cyc(3);
        chk("empty buffer", 32'h88, ioO);
        $display("test extest finished");
    endtask

    task automatic t_probe();
        probePinI = 5'h1F;
        probeDrv = 5'h15;
        userProbeO = 5'h0A;
        userProbeOe = 5'h1C;
        probeMode = 1'b1;
        cyc(4);
        chk("probe drive", 32'h15, probePinO);
        chk("probe enable", `PRB_OE_MASK, probePinOe);
        chk("probe sense", 5'h1F & ~`PRB_OE_MASK, probeSense);
        chk("probe blocks user", 32'h0, probeCoreI);
        probeMode = 1'b0;
        cyc(4);
        chk("user drive", 32'h0A, probePinO);
        chk("user enable", 32'h1C, probePinOe);
        chk("user input", 32'h1F, probeCoreI);
        chk("sense idle", 32'h0, probeSense);
        $display("test probe finished");
    endtask

    task automatic t_forceReset();
        logic q;
        tester.step(1'b1, 1'b0, q);
        tester.step(1'b0, 1'b0, q);
        tester.step(1'b0, 1'b0, q);
        tester.forceReset();
        tester.idle(1);
        cyc(8);
        chk("extest cleared", 32'h0, extestOn);
        chk("core enable back", 32'hF0, ioOe);
        tester.scan(1'b0, 32, 32'h0, dout, oe);
        chk("idcode after forced reset", ID_EXP, dout);
        $display("test forced reset finished");
    endtask

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        drvReady = 1'b0;
        probeMode = 1'b0;
        ioI = '0;
        coreO = 8'hFF;
        coreOe = 8'hFF;
        probePinI = '0;
        probeDrv = '0;
        userProbeO = 5'h1F;
        userProbeOe = 5'h1F;
        cyc(3);
        chk("ioOe in reset", 32'h0, ioOe);
        chk("probe enable in reset", 32'h0, probePinOe);
        cyc(2);
        rst = 1'b0;
        cyc(2);
        t_reset();
        t_bypass();
        t_sample();
        t_extest();
        t_probe();
        t_forceReset();
        complete_run();
    end

    initial begin
        #400000;
        num_errors++;
        $display("unexpected watchdog: expected done, seen timeout");
        complete_run();
    end
endmodule
